/* tw_pkg.sv */
package tw_pkg;

  // Counter and bus geometry
  localparam int CW = 16;
  localparam int AW = 5;
  localparam int DW = 32;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL_A  = 5'h00;
  localparam logic [AW-1:0] OFS_CTRL_B  = 5'h04;
  localparam logic [AW-1:0] OFS_CMP_A   = 5'h08;
  localparam logic [AW-1:0] OFS_CMP_B   = 5'h0c;
  localparam logic [AW-1:0] OFS_CAPTURE = 5'h10;
  localparam logic [AW-1:0] OFS_STATUS  = 5'h14;
  localparam logic [AW-1:0] OFS_PIN     = 5'h18;
  localparam logic [AW-1:0] OFS_COUNT   = 5'h1c;

  // Field positions in timer_ctrl_a
  localparam int COM_A_LSB  = 6;
  localparam int COM_B_LSB  = 4;
  localparam int WGM_LO_LSB = 0;
  // Field positions in timer_ctrl_b
  localparam int WGM_HI_LSB = 3;
  localparam int RUN_BIT    = 0;
  // Status and pin control bits
  localparam int OVF_BIT    = 0;
  localparam int DDR_A_BIT  = 0;
  localparam int DDR_B_BIT  = 1;
  localparam int PORT_A_BIT = 2;
  localparam int PORT_B_BIT = 3;

  // Fixed TOP values and counter ends
  localparam logic [CW-1:0] TOP_MAX  = 16'hffff;
  localparam logic [CW-1:0] TOP_8    = 16'h00ff;
  localparam logic [CW-1:0] TOP_9    = 16'h01ff;
  localparam logic [CW-1:0] TOP_10   = 16'h03ff;
  localparam logic [CW-1:0] BOTTOM   = 16'h0000;
  localparam logic [CW-1:0] CNT_STEP = 16'h0001;

  // Waveform modes that the channel A toggle depends on
  localparam logic [3:0] MODE_PFC_CAP   = 4'h8;
  localparam logic [3:0] MODE_PC_CMPA   = 4'hb;
  localparam logic [3:0] MODE_FAST_CAP  = 4'he;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hf;

  // Compare-output field codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOG = 2'h1;
  localparam logic [1:0] COM_CLR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  typedef enum logic [1:0] {CLS_NONPWM, CLS_FAST, CLS_DUAL} tw_cls_e;
  typedef enum logic [1:0] {UPD_IMM, UPD_TOP, UPD_BOT} tw_upd_e;
  typedef enum logic [1:0] {OVF_MAX, OVF_TOP, OVF_BOT} tw_ovf_e;
  typedef enum logic [1:0] {SRC_FIXED, SRC_CMPA, SRC_CAP} tw_src_e;

  // Decoded waveform mode
  typedef struct packed {
    tw_cls_e         cls;
    tw_upd_e         upd;
    tw_ovf_e         ovf;
    tw_src_e         src;
    logic [CW-1:0]   top_fix;
  } tw_mode_s;

  // Per-channel controls handed to the waveform unit
  typedef struct packed {
    tw_cls_e    cls;
    logic [1:0] com;
    logic       toggle_ok;
    logic       tick;
    logic       match;
    logic       at_top;
    logic       cmp_eq_top;
    logic       up;
  } tw_wave_in_s;

  // Pin drive pair
  typedef struct packed {
    logic out;
    logic oe;
  } tw_pin_s;

endpackage

/* tw_tick_div.sv */
`timescale 1ns/100ps
module tw_tick_div import tw_pkg::*; #(
  parameter int DIV = 1
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Timer clock enable
  output logic      tick
);
  localparam int DCW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [DCW-1:0] LAST = DCW'(DIV - 1);

  typedef struct packed {
    logic [DCW-1:0] cnt;
  } tw_div_st_s;

  tw_div_st_s s_r;
  tw_div_st_s s_nxt;

  // Wrap at the last count so the enable is one cycle wide
  always_comb begin
    s_nxt = s_r;
    s_nxt.cnt = (s_r.cnt == LAST) ? '0 : s_r.cnt + DCW'(1);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = (s_r.cnt == LAST);
endmodule // tw_tick_div

/* tw_wave_unit.sv */
`timescale 1ns/100ps
module tw_wave_unit import tw_pkg::*; (
  // Clock and reset
  input  wire logic  clk_sys,
  input  wire logic  reset,
  // Channel controls
  input  tw_wave_in_s ctl,
  // Waveform level and pin takeover
  output logic        wave,
  output logic        connected
);
  typedef struct packed {
    logic wave;
  } tw_wave_st_s;

  tw_wave_st_s s_r;
  tw_wave_st_s s_nxt;

  // Field 00, or 01 where toggling is not allowed, leaves the port alone
  assign connected = (ctl.com != COM_OFF) && ((ctl.com != COM_TOG) || ctl.toggle_ok);

  // Output action per mode class
  always_comb begin
    s_nxt = s_r;
    if (ctl.tick) begin
      case (ctl.cls)
        CLS_NONPWM: begin
          if (ctl.match) begin
            case (ctl.com)
              COM_TOG: s_nxt.wave = ~s_r.wave;
              COM_CLR: s_nxt.wave = 1'b0;
              COM_SET: s_nxt.wave = 1'b1;
              default: s_nxt.wave = s_r.wave;
            endcase
          end
        end
        CLS_FAST: begin
          if (ctl.com[1]) begin
            // TOP action first; a match at TOP is dropped
            if (ctl.at_top) begin
              s_nxt.wave = (ctl.com == COM_CLR);
            end else if (ctl.match && !ctl.cmp_eq_top) begin
              s_nxt.wave = (ctl.com == COM_SET);
            end
          end else if ((ctl.com == COM_TOG) && ctl.toggle_ok && ctl.match) begin
            s_nxt.wave = ~s_r.wave;
          end
        end
        CLS_DUAL: begin
          if (ctl.match) begin
            if (ctl.com[1]) begin
              s_nxt.wave = (ctl.com == COM_SET) ~^ ctl.up;
            end else if ((ctl.com == COM_TOG) && ctl.toggle_ok) begin
              s_nxt.wave = ~s_r.wave;
            end
          end
        end
        default: s_nxt.wave = s_r.wave;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wave = s_r.wave;
endmodule // tw_wave_unit

/* tw_timer_top.sv */
// Behaviour
// - Nonzero A field hands pin A to waveform; the code keeps the port for 01 in modes 1..3 and 5..7
// - Nonzero B field hands pin B to waveform; the code keeps the port for 01 in every PWM mode
// - Pin driver enabled only by direction bit
// - Field meaning follows current mode class
// - Field 00 disconnects waveform in every mode
// - Non-PWM match: 01 toggle, 10 low, 11 high
// - Fast PWM 10: clear on match, set TOP
// - Fast PWM 11: set on match, clear TOP
// - Fast PWM 01 toggles A in 14/15 only
// - Fast PWM compare equal TOP: only TOP action
// - Dual-slope 01 toggles A in 8..11 only
// - Dual-slope 10: clear up, set down
// - Dual-slope 11: set up, clear down
// - Mode is low bits here, high bits elsewhere
// - Mode 0 normal, TOP max, immediate, flag MAX
// - Modes 4/12 clear on compare A/capture
// - Fast PWM TOPs, update and flag at TOP
// - Phase correct TOPs, update TOP, flag BOTTOM
// - Modes 8/9 reload and flag at BOTTOM
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module tw_timer_top import tw_pkg::*; #(
  parameter int PRESCALE = 1
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          reset,
  // Avalon-MM slave
  input  wire logic [AW-1:0] avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [DW-1:0] avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [DW-1:0]      avs_readdata,
  output logic               avs_waitrequest,
  // Compare channel pins
  output tw_pin_s            chan_a_wave_out,
  output tw_pin_s            chan_b_wave_out,
  // Overflow flag level
  output logic               overflow_flag
);

  typedef struct packed {
    logic [1:0]    chan_a_out_mode;
    logic [1:0]    chan_b_out_mode;
    logic [1:0]    wave_gen_mode_low;
    logic [1:0]    wave_gen_mode_high;
    logic          run;
    logic [CW-1:0] cmp_buf_a;
    logic [CW-1:0] cmp_buf_b;
    logic [CW-1:0] compare_reg_a;
    logic [CW-1:0] compare_reg_b;
    logic [CW-1:0] capture_reg;
    logic          ovf;
    logic [1:0]    ddr;
    logic [1:0]    port;
    logic [CW-1:0] cnt;
    logic          down;
    logic          ack;
    logic [DW-1:0] rdata;
  } tw_top_st_s;

  tw_top_st_s    s_r;
  tw_top_st_s    s_nxt;
  logic          tick;
  logic          step;
  logic [3:0]    wave_gen_mode;
  tw_mode_s      md;
  logic [CW-1:0] top_v;
  logic          at_top;
  logic          at_bot;
  logic          match_a;
  logic          match_b;
  logic          tog_a;
  logic          tog_b;
  logic          req;
  logic          wr_go;
  logic          wave_a;
  logic          wave_b;
  logic          conn_a;
  logic          conn_b;
  tw_wave_in_s   ctl_a;
  tw_wave_in_s   ctl_b;

  // Mode table; mode 13 is left to fall into normal counting
  function automatic tw_mode_s mode_decode(input logic [3:0] m);
    tw_mode_s d;
    d = '{cls: CLS_NONPWM, upd: UPD_IMM, ovf: OVF_MAX, src: SRC_FIXED, top_fix: TOP_MAX};
    case (m)
      4'h1, 4'h2, 4'h3: begin
        d.cls = CLS_DUAL;
        d.upd = UPD_TOP;
        d.ovf = OVF_BOT;
      end
      4'h4: d.src = SRC_CMPA;
      4'h5, 4'h6, 4'h7: begin
        d.cls = CLS_FAST;
        d.upd = UPD_TOP;
        d.ovf = OVF_TOP;
      end
      4'h8: begin
        d.cls = CLS_DUAL;
        d.upd = UPD_BOT;
        d.ovf = OVF_BOT;
        d.src = SRC_CAP;
      end
      4'h9: begin
        d.cls = CLS_DUAL;
        d.upd = UPD_BOT;
        d.ovf = OVF_BOT;
        d.src = SRC_CMPA;
      end
      4'ha: begin
        d.cls = CLS_DUAL;
        d.upd = UPD_TOP;
        d.ovf = OVF_BOT;
        d.src = SRC_CAP;
      end
      4'hb: begin
        d.cls = CLS_DUAL;
        d.upd = UPD_TOP;
        d.ovf = OVF_BOT;
        d.src = SRC_CMPA;
      end
      4'hc: d.src = SRC_CAP;
      4'he: begin
        d.cls = CLS_FAST;
        d.upd = UPD_TOP;
        d.ovf = OVF_TOP;
        d.src = SRC_CAP;
      end
      4'hf: begin
        d.cls = CLS_FAST;
        d.upd = UPD_TOP;
        d.ovf = OVF_TOP;
        d.src = SRC_CMPA;
      end
      default: d.src = SRC_FIXED;
    endcase
    // Low mode bits pick the fixed 8, 9 or 10 bit TOP
    case (m[1:0])
      2'h1:    if (m[3:2] != 2'h3 && m != 4'h9) d.top_fix = TOP_8;
      2'h2:    if (m[3] == 1'b0) d.top_fix = TOP_9;
      2'h3:    if (m[3] == 1'b0) d.top_fix = TOP_10;
      default: d.top_fix = d.top_fix;
    endcase
    return d;
  endfunction

  // Byte-lane merge for a write into a narrower register
  function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] old,
                                             input logic [DW-1:0] wd,
                                             input logic [3:0]    be);
    logic [DW-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  // Timer clock enable from the prescale divider
  tw_tick_div #(
    .DIV (PRESCALE)
  ) u_div (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tick    (tick)
  );

  assign step = tick & s_r.run;

  // Full mode joins the two halves held in separate registers
  assign wave_gen_mode = {s_r.wave_gen_mode_high, s_r.wave_gen_mode_low};
  assign md            = mode_decode(wave_gen_mode);

  // TOP source: fixed, compare A or capture
  always_comb begin
    case (md.src)
      SRC_CMPA: top_v = s_r.compare_reg_a;
      SRC_CAP:  top_v = s_r.capture_reg;
      default:  top_v = md.top_fix;
    endcase
  end

  assign at_top  = (s_r.cnt == top_v);
  assign at_bot  = (s_r.cnt == BOTTOM);
  assign match_a = (s_r.cnt == s_r.compare_reg_a);
  assign match_b = (s_r.cnt == s_r.compare_reg_b);

  // Toggle on 01 is legal for both channels in non-PWM modes, and only for channel A in PWM modes 8..11, 14 and 15
  always_comb begin
    case (md.cls)
      CLS_FAST: tog_a = (wave_gen_mode == MODE_FAST_CAP) || (wave_gen_mode == MODE_FAST_CMPA);
      CLS_DUAL: tog_a = (wave_gen_mode >= MODE_PFC_CAP) && (wave_gen_mode <= MODE_PC_CMPA);
      default:  tog_a = 1'b1;
    endcase
  end
  assign tog_b = (md.cls == CLS_NONPWM);

  // Bus handshake: one wait cycle, then the answer
  assign req             = avs_read | avs_write;
  assign wr_go           = avs_write & s_r.ack;
  assign avs_waitrequest = req & ~s_r.ack;
  assign avs_readdata    = s_r.rdata;

  // Next state: bus side first, then the counter so hardware sets win
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = req & ~s_r.ack;
    s_nxt.rdata = '0;
    if (avs_read && !s_r.ack) begin
      case (avs_address)
        OFS_CTRL_A:  s_nxt.rdata = DW'({s_r.chan_a_out_mode, s_r.chan_b_out_mode,
                                        2'h0, s_r.wave_gen_mode_low});
        OFS_CTRL_B:  s_nxt.rdata = DW'({s_r.wave_gen_mode_high, 2'h0, s_r.run});
        OFS_CMP_A:   s_nxt.rdata = DW'(s_r.cmp_buf_a);
        OFS_CMP_B:   s_nxt.rdata = DW'(s_r.cmp_buf_b);
        OFS_CAPTURE: s_nxt.rdata = DW'(s_r.capture_reg);
        OFS_STATUS:  s_nxt.rdata = DW'(s_r.ovf);
        OFS_PIN:     s_nxt.rdata = DW'({s_r.port, s_r.ddr});
        OFS_COUNT:   s_nxt.rdata = DW'(s_r.cnt);
        default:     s_nxt.rdata = '0;
      endcase
    end

    // Register writes land on the edge that ends the wait
    if (wr_go && avs_byteenable[0]) begin
      case (avs_address)
        OFS_CTRL_A: begin
          s_nxt.chan_a_out_mode   = avs_writedata[COM_A_LSB +: 2];
          s_nxt.chan_b_out_mode   = avs_writedata[COM_B_LSB +: 2];
          s_nxt.wave_gen_mode_low = avs_writedata[WGM_LO_LSB +: 2];
        end
        OFS_CTRL_B: begin
          s_nxt.wave_gen_mode_high = avs_writedata[WGM_HI_LSB +: 2];
          s_nxt.run                = avs_writedata[RUN_BIT];
        end
        OFS_STATUS: if (avs_writedata[OVF_BIT]) s_nxt.ovf = 1'b0;
        OFS_PIN: begin
          s_nxt.ddr[0]  = avs_writedata[DDR_A_BIT];
          s_nxt.ddr[1]  = avs_writedata[DDR_B_BIT];
          s_nxt.port[0] = avs_writedata[PORT_A_BIT];
          s_nxt.port[1] = avs_writedata[PORT_B_BIT];
        end
        default: s_nxt.ovf = s_r.ovf;
      endcase
    end
    if (wr_go) begin
      case (avs_address)
        OFS_CMP_A:   s_nxt.cmp_buf_a   = CW'(be_merge(DW'(s_r.cmp_buf_a), avs_writedata,
                                                      avs_byteenable));
        OFS_CMP_B:   s_nxt.cmp_buf_b   = CW'(be_merge(DW'(s_r.cmp_buf_b), avs_writedata,
                                                      avs_byteenable));
        OFS_CAPTURE: s_nxt.capture_reg = CW'(be_merge(DW'(s_r.capture_reg), avs_writedata,
                                                      avs_byteenable));
        default:     s_nxt.capture_reg = s_r.capture_reg;
      endcase
    end

    // Counting sequence per mode class
    if (step) begin
      if (md.cls == CLS_DUAL) begin
        if (!s_r.down) begin
          if (at_top) begin
            s_nxt.down = 1'b1;
            s_nxt.cnt  = s_r.cnt - CNT_STEP;
          end else begin
            s_nxt.cnt = s_r.cnt + CNT_STEP;
          end
        end else if (at_bot) begin
          s_nxt.down = 1'b0;
          s_nxt.cnt  = s_r.cnt + CNT_STEP;
        end else begin
          s_nxt.cnt = s_r.cnt - CNT_STEP;
        end
      end else begin
        // Single slope restarts from BOTTOM after TOP
        s_nxt.down = 1'b0;
        s_nxt.cnt  = at_top ? BOTTOM : s_r.cnt + CNT_STEP;
      end

      // Overflow point per mode; set beats a same-cycle clear
      case (md.ovf)
        OVF_MAX: if (s_r.cnt == TOP_MAX) s_nxt.ovf = 1'b1;
        OVF_TOP: if (at_top) s_nxt.ovf = 1'b1;
        OVF_BOT: if (at_bot && s_r.down) s_nxt.ovf = 1'b1;
        default: s_nxt.ovf = s_nxt.ovf;
      endcase

      // Buffered compare reload point
      if ((md.upd == UPD_TOP && at_top) || (md.upd == UPD_BOT && at_bot && s_r.down)) begin
        s_nxt.compare_reg_a = s_r.cmp_buf_a;
        s_nxt.compare_reg_b = s_r.cmp_buf_b;
      end
    end

    // Non-buffered modes see compare writes at once
    if (md.upd == UPD_IMM) begin
      s_nxt.compare_reg_a = s_nxt.cmp_buf_a;
      s_nxt.compare_reg_b = s_nxt.cmp_buf_b;
    end

    // A counter write overrides the step it collides with
    if (wr_go && avs_address == OFS_COUNT) begin
      s_nxt.cnt = CW'(be_merge(DW'(s_r.cnt), avs_writedata, avs_byteenable));
    end
  end

  // All control state resets to zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Channel controls for the two waveform units
  assign ctl_a = '{cls: md.cls, com: s_r.chan_a_out_mode, toggle_ok: tog_a, tick: step,
                   match: match_a, at_top: at_top,
                   cmp_eq_top: (s_r.compare_reg_a == top_v), up: ~s_r.down};
  assign ctl_b = '{cls: md.cls, com: s_r.chan_b_out_mode, toggle_ok: tog_b, tick: step,
                   match: match_b, at_top: at_top,
                   cmp_eq_top: (s_r.compare_reg_b == top_v), up: ~s_r.down};

  tw_wave_unit u_wave_a (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .ctl       (ctl_a),
    .wave      (wave_a),
    .connected (conn_a)
  );

  tw_wave_unit u_wave_b (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .ctl       (ctl_b),
    .wave      (wave_b),
    .connected (conn_b)
  );

  // Pin mux; the direction bit alone decides whether the pin is driven
  assign chan_a_wave_out.out = conn_a ? wave_a : s_r.port[0];
  assign chan_b_wave_out.out = conn_b ? wave_b : s_r.port[1];
  assign chan_a_wave_out.oe  = s_r.ddr[0];
  assign chan_b_wave_out.oe  = s_r.ddr[1];
  assign overflow_flag       = s_r.ovf;
endmodule // tw_timer_top

/* tw_timer_chk.sv */
`timescale 1ns/100ps
module tw_timer_chk import tw_pkg::*; #(
  parameter int PRESCALE = 1
) (
  // Clock and reset
  input wire logic          clk_sys,
  input wire logic          reset,
  // Register bus
  input wire logic [AW-1:0] avs_address,
  input wire logic          avs_read,
  input wire logic          avs_write,
  input wire logic [DW-1:0] avs_writedata,
  input wire logic [3:0]    avs_byteenable,
  input wire logic [DW-1:0] avs_readdata,
  input wire logic          avs_waitrequest,
  // Pins and flag
  input wire tw_pin_s       chan_a_wave_out,
  input wire tw_pin_s       chan_b_wave_out,
  input wire logic          overflow_flag
);
  logic       wr_ok;
  logic       rd_ok;
  logic [7:0] ctl_r;
  logic [2:0] hi_r;
  logic [3:0] pin_r;
  logic [3:0] md;
  logic       fast_m;
  logic       dual_m;

  // Accepted transfers and decoded mode class
  assign wr_ok  = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_ok  = avs_read && !avs_waitrequest;
  assign md     = {hi_r[2:1], ctl_r[1:0]};
  assign fast_m = md inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
  assign dual_m = md inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};

  // Shadow of control and pin registers, updated at the accepting edge
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctl_r <= 8'h00;
      hi_r  <= 3'h0;
      pin_r <= 4'h0;
    end else if (wr_ok) begin
      if (avs_address == OFS_CTRL_A) ctl_r <= avs_writedata[7:0];
      if (avs_address == OFS_CTRL_B) hi_r <= {avs_writedata[4:3], avs_writedata[RUN_BIT]};
      if (avs_address == OFS_PIN) pin_r <= avs_writedata[3:0];
    end
  end

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_dir_a; chan_a_wave_out.oe == pin_r[DDR_A_BIT]; endproperty
  a_dir_a: assert property (p_dir_a)
    else $error("pin A driver enable differs from direction bit");
  property p_dir_b;
    wr_ok && avs_address == OFS_PIN |=> chan_b_wave_out.oe == $past(avs_writedata[DDR_B_BIT]);
  endproperty
  a_dir_b: assert property (p_dir_b)
    else $error("pin B driver enable did not follow write");
  property p_off_a; ctl_r[7:6] == COM_OFF |-> chan_a_wave_out.out == pin_r[PORT_A_BIT]; endproperty
  a_off_a: assert property (p_off_a)
    else $error("pin A not at port value while disconnected");
  property p_off_b; ctl_r[5:4] == COM_OFF |-> chan_b_wave_out.out == pin_r[PORT_B_BIT]; endproperty
  a_off_b: assert property (p_off_b)
    else $error("pin B not at port value while disconnected");
  property p_tog_a;
    md inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7} && ctl_r[7:6] == COM_TOG
      |-> chan_a_wave_out.out == pin_r[PORT_A_BIT];
  endproperty
  a_tog_a: assert property (p_tog_a)
    else $error("pin A toggle code not disconnected");
  property p_tog_b;
    (fast_m || dual_m) && ctl_r[5:4] == COM_TOG |-> chan_b_wave_out.out == pin_r[PORT_B_BIT];
  endproperty
  a_tog_b: assert property (p_tog_b)
    else $error("pin B toggle code not disconnected");
  property p_rd_ctl;
    rd_ok && avs_address == OFS_CTRL_A |-> avs_readdata == {24'h0, ctl_r & 8'hf3};
  endproperty
  a_rd_ctl: assert property (p_rd_ctl)
    else $error("control A read value wrong");
  property p_rd_mode; rd_ok && avs_address == OFS_CTRL_B |-> avs_readdata[4:3] == hi_r[2:1]; endproperty
  a_rd_mode: assert property (p_rd_mode)
    else $error("mode high bits read wrong");
  property p_ovf_quiet; !hi_r[0] && !overflow_flag |=> !overflow_flag; endproperty
  a_ovf_quiet: assert property (p_ovf_quiet)
    else $error("overflow flag set while counter stopped");

  // Main scenarios reached
  c_fast: cover property (fast_m && hi_r[0]);
  c_dual: cover property (dual_m && hi_r[0]);
  c_ovf: cover property ($rose(overflow_flag));
endmodule // tw_timer_chk

bind tw_timer_top tw_timer_chk #(.PRESCALE(PRESCALE)) i_chk (
  .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .chan_a_wave_out(chan_a_wave_out), .chan_b_wave_out(chan_b_wave_out),
  .overflow_flag(overflow_flag)
);

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top import tw_pkg::*;;
  logic          clk_sys = 1'b0;
  logic          reset   = 1'b1;
  logic [AW-1:0] av_a    = '0;
  logic          av_r    = 1'b0;
  logic          av_w    = 1'b0;
  logic [DW-1:0] av_wd   = '0;
  logic [DW-1:0] av_rd;
  logic          av_wt;
  tw_pin_s       pin_a;
  tw_pin_s       pin_b;
  logic          ovf;
  int            n_errors   = 0;
  int            n_compared = 0;
  logic [3:0]    ml [10]    = '{4'h5, 4'h6, 4'h7, 4'he, 4'hf, 4'h1, 4'h2, 4'h3, 4'h8, 4'ha};

  // System clock
  always #20 clk_sys = ~clk_sys;

  tw_timer_top #(.PRESCALE(1)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .avs_address(av_a), .avs_read(av_r),
    .avs_write(av_w), .avs_writedata(av_wd), .avs_byteenable(4'hf),
    .avs_readdata(av_rd), .avs_waitrequest(av_wt), .chan_a_wave_out(pin_a),
    .chan_b_wave_out(pin_b), .overflow_flag(ovf)
  );

  // Verdict and end of run
  task automatic test_done();
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [DW-1:0] s, input logic [DW-1:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One bus transfer; waitrequest and read data are taken at the same rising edge,
  // and the request is dropped only there; bounded so a hang ends the run
  task automatic bus(input logic w, input logic [AW-1:0] ad, input logic [DW-1:0] d,
                     output logic [DW-1:0] q);
    int n = 0;
    @(posedge clk_sys);
    av_a  <= ad;
    av_wd <= d;
    av_w  <= w;
    av_r  <= !w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (av_wt !== 1'b0 && n < 40);
    q = av_rd;
    if (av_wt !== 1'b0) begin
      chk("waitrequest", {31'h0, av_wt}, 32'h0);
      test_done();
    end
    av_w <= 1'b0;
    av_r <= 1'b0;
  endtask

  task automatic wr(input logic [AW-1:0] ad, input logic [DW-1:0] d);
    logic [DW-1:0] q;
    bus(1'b1, ad, d, q);
  endtask

  // Configure while stopped, run a while, stop and fetch the count
  task automatic run(input logic [3:0] md, input logic [1:0] ka, kb,
                     input logic [15:0] ca, cb, cap, st, input int cyc, output logic [15:0] k);
    logic [DW-1:0] q;
    // Park in mode 0 so buffered compares take the new values at once
    wr(OFS_CTRL_B, 32'h0);
    wr(OFS_CTRL_A, {24'h0, ka, kb, 4'h0});
    wr(OFS_CMP_A, {16'h0, ca});
    wr(OFS_CMP_B, {16'h0, cb});
    wr(OFS_CAPTURE, {16'h0, cap});
    wr(OFS_COUNT, {16'h0, st});
    wr(OFS_CTRL_A, {24'h0, ka, kb, 2'h0, md[1:0]});
    wr(OFS_CTRL_B, {27'h0, md[3:2], 3'h1});
    repeat (cyc) @(posedge clk_sys);
    wr(OFS_CTRL_B, {27'h0, md[3:2], 3'h0});
    bus(1'b0, OFS_CTRL_B, '0, q);
    chk("mode_high", {30'h0, q[4:3]}, {30'h0, md[3:2]});
    bus(1'b0, OFS_COUNT, '0, q);
    k = q[15:0];
  endtask

  // Level a PWM channel should show once stopped at count k
  function automatic logic lvl(input logic [1:0] kd, input logic [15:0] k, c,
                               input logic fs, input logic prt);
    logic lt;
    lt = fs ? (k <= c) : (k < c);
    if (kd == COM_TOG) return prt;
    return (kd == COM_CLR) ? lt : !lt;
  endfunction

  // Main sequence
  initial begin
    logic [DW-1:0] v;
    logic [DW-1:0] q;
    logic [15:0]   k, c1, c2, tp;
    logic [3:0]    md, pr;
    logic [1:0]    ka, kb;
    logic          fs;
    logic          e;
    v = $urandom(32'h2be3);
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    bus(1'b0, OFS_CTRL_A, '0, q);
    chk("ctrl_a_reset", q, 32'h0);
    chk("pins_reset", {27'h0, ovf, pin_a, pin_b}, 32'h0);
    // Register readback, direction bits and port fallback
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      pr = 4'($urandom);
      if (i == 0) v[7:4] = 4'h0;
      wr(OFS_CTRL_A, v);
      wr(OFS_PIN, {28'h0, pr});
      bus(1'b0, OFS_CTRL_A, '0, q);
      chk("ctrl_a", q, {24'h0, v[7:0] & 8'hf3});
      chk("dir", {30'h0, pin_a.oe, pin_b.oe}, {30'h0, pr[0], pr[1]});
      if (v[7:6] == COM_OFF) chk("port_a", {31'h0, pin_a.out}, {31'h0, pr[2]});
    end
    // Non-PWM match actions: toggle, clear, set on both channels
    for (int i = 1; i < 4; i++) begin
      e = (i != 2);
      wr(OFS_PIN, {28'h0, !e, !e, 2'h3});
      run(4'h0, i[1:0], i[1:0], 16'h0100, 16'h0100, 16'h0, 16'h00fe, 6, k);
      chk("nonpwm", {28'h0, pin_a, pin_b}, {28'h0, e, 1'b1, e, 1'b1});
    end
    chk("flag_idle", {31'h0, ovf}, 32'h0);
    run(4'h0, 2'h0, 2'h0, 16'h0, 16'h0, 16'h0, 16'hfffc, 6, k);
    chk("flag_max", {31'h0, ovf}, 32'h1);
    wr(OFS_STATUS, 32'h1);
    // The clear lands at the edge the write ends on; look one edge later
    @(posedge clk_sys);
    chk("flag_clear", {31'h0, ovf}, 32'h0);
    // Clear on compare, TOP from compare A or capture
    for (int i = 0; i < 2; i++) begin
      md = i ? 4'hc : 4'h4;
      tp = 16'(16 + $urandom % 48);
      run(md, 2'h0, 2'h0, i ? 16'hffff : tp, tp, i ? tp : 16'hffff, 16'h0, 3 * int'(tp), k);
      chk("ctc_count", {31'h0, k <= tp}, 32'h1);
      chk("ctc_flag", {31'h0, ovf}, 32'h0);
    end
    // Fast and dual-slope PWM with random compares; TOP compare as corner
    for (int r = 0; r < 15; r++) begin
      md = ml[r % 10];
      fs = md[2];
      tp = md[3] ? 16'(32'h20 + $urandom % 224) : (16'h0080 << md[1:0]) - 16'h1;
      ka = md[3] ? 2'(2 + $urandom % 2) : 2'(1 + $urandom % 3);
      kb = 2'(1 + $urandom % 3);
      c1 = (md == 4'hf) ? tp : 16'(1 + $urandom % (tp - 1));
      c2 = (fs && r >= 10) ? tp : 16'(1 + $urandom % (tp - 1));
      pr = 4'($urandom) | 4'h3;
      wr(OFS_PIN, {28'h0, pr});
      run(md, ka, kb, c1, c2, tp, 16'h0, (fs ? 2 : 4) * int'(tp) + 20 + $urandom % 64, k);
      if (fs || k != c1)
        chk("pwm_a", {30'h0, pin_a}, {30'h0, lvl(ka, k, c1, fs, pr[2]), 1'b1});
      if (fs || k != c2)
        chk("pwm_b", {30'h0, pin_b}, {30'h0, lvl(kb, k, c2, fs, pr[3]), 1'b1});
      chk("pwm_flag", {31'h0, ovf}, 32'h1);
      wr(OFS_STATUS, 32'h1);
    end
    test_done();
  end
endmodule // tb_top
